/* File: include/uart_rx_pkg.sv */
// Constants and carrier types for the asynchronous serial receiver
package uart_rx_pkg;
    localparam int unsigned CLK_HZ          = 250_000_000;
    localparam int unsigned DIV_LOW_8       = 64;
    localparam int unsigned DIV_ONE_SEL     = 16;
    localparam int unsigned DIV_BOTH_SEL    = 4;
    localparam int unsigned SAMPLE_PER_BIT  = 4;
    localparam logic [7:0]  DIVISOR_LOW_RST  = 8'h00;
    localparam logic [7:0]  DIVISOR_HIGH_RST = 8'h00;
    localparam int unsigned DATA_BITS       = 8;
    localparam int unsigned BUF_DEPTH       = 2;

    typedef struct packed {
        logic [7:0] data;
        logic       ninth;
        logic       framing_err;
    } rx_char_t;

    typedef struct packed {
        logic serial_port_enable;
        logic sync_mode_select;
        logic nine_bit_receive_select;
        logic continuous_receive_enable;
        logic address_detect_enable;
        logic high_speed_baud_select;
        logic wide_baud_timer_select;
    } rx_ctrl_t;

    typedef struct packed {
        logic receive_interrupt_enable;
        logic peripheral_interrupt_enable;
        logic global_interrupt_enable;
    } irq_en_t;
endpackage : uart_rx_pkg

/* File: core/rx_char_buffer.sv */
// Two-entry character buffer with valid/ready on both sides
`timescale 1ns/1ps
module rx_char_buffer #(
    parameter int unsigned DEPTH = uart_rx_pkg::BUF_DEPTH
) (
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    input  wire logic                 in_valid,
    output logic                      in_ready,
    input  wire uart_rx_pkg::rx_char_t in_data,
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output uart_rx_pkg::rx_char_t     out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    uart_rx_pkg::rx_char_t mem_r [DEPTH];
    logic [AW-1:0]         wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]           cnt_r, cnt_nxt;
    logic                  push, pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wp_nxt  = push ? bump(wp_r) : wp_r;
        rp_nxt  = pop ? bump(rp_r) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wp_r     <= '0;
            rp_r     <= '0;
            cnt_r    <= '0;
            out_data <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
            // Registered head; a push into an empty buffer goes straight to it
            if (push && (cnt_r == '0 || (pop && cnt_r == (AW+1)'(1))))
                out_data <= in_data;
            else if (pop)
                out_data <= mem_r[bump(rp_r)];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push)
            mem_r[wp_r] <= in_data;
    end
endmodule : rx_char_buffer

/* File: core/uart_receiver.sv */
// Asynchronous serial receiver with programmable baud timer
//
// Operation
// - Interrupt out only when receive, peripheral and global enables all set.
// - Nine-bit select captures a ninth data bit, readable in status.
// - Characters accepted only while continuous receive enable is set.
// - Flag set when a character enters the buffer; interrupt if enabled.
// - Data read returns low eight bits of the oldest buffered character.
// - Overrun clears only by clearing continuous receive enable.
// - Address detect in nine-bit mode keeps only ninth-bit-set characters.
// - Characters accepted under address detect in nine-bit mode show ninth bit one.
// - Address detect off: every character is buffered and flags, except while overrun is set or the buffer is full.
// - Baud timer free-runs, 8 bits wide, 16 bits with wide select.
// - Divisor pair sets the baud period, shared by both modes.
// - Multiplier depends on both selects async; fixed at 4 sync, both selects ignored.
// - Low-speed 8-bit async: baud equals clock over 64 times divisor+1.
// - Any divisor write resets the baud timer at once.
// - Receive-idle status bit shows no character in progress.
`timescale 1ns/1ps
module uart_receiver (
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire logic                  rx_line,
    input  wire uart_rx_pkg::rx_ctrl_t ctrl,
    input  wire uart_rx_pkg::irq_en_t  irq_en,
    input  wire logic [7:0]            baud_divisor_high,
    input  wire logic [7:0]            baud_divisor_low,
    input  wire logic                  divisor_write,
    input  wire logic                  receive_data_read,
    output logic [7:0]                 receive_data_reg,
    output logic                       rx_ninth_bit,
    output logic                       framing_error_flag,
    output logic                       overrun_error_flag,
    output logic                       receive_interrupt_flag,
    output logic                       receive_idle_status,
    output logic                       irq
);
    ////////////////////////////////////////////////////////////////////////
    // Baud timer: one tick per sample, SAMPLE_PER_BIT samples per bit
    logic [15:0] baud_rate_timer_r, baud_rate_timer_nxt;
    logic [3:0]  presc_r, presc_nxt;
    logic [3:0]  presc_top;
    logic [15:0] divisor;
    logic        sample_tick;

    // Prescale per sample = multiplier / samples per bit
    function automatic logic [3:0] presc_last(input logic hs, input logic wide,
                                              input logic sync_m);
        int unsigned m;
        if (sync_m)
            m = wide ? uart_rx_pkg::DIV_BOTH_SEL : uart_rx_pkg::DIV_BOTH_SEL;
        else if (hs && wide)
            m = uart_rx_pkg::DIV_BOTH_SEL;
        else if (hs || wide)
            m = uart_rx_pkg::DIV_ONE_SEL;
        else
            m = uart_rx_pkg::DIV_LOW_8;
        presc_last = 4'(m / uart_rx_pkg::SAMPLE_PER_BIT - 1);
    endfunction : presc_last

    always_comb begin
        divisor = ctrl.wide_baud_timer_select ? {baud_divisor_high, baud_divisor_low}
                                              : {8'h00, baud_divisor_low};
        presc_top = presc_last(ctrl.high_speed_baud_select, ctrl.wide_baud_timer_select,
                               ctrl.sync_mode_select);
        sample_tick = (presc_r == presc_top) && (baud_rate_timer_r == 16'h0000);
        presc_nxt = presc_r;
        baud_rate_timer_nxt = baud_rate_timer_r;
        if (divisor_write) begin
            presc_nxt = 4'h0;
            baud_rate_timer_nxt = divisor;
        end else if (baud_rate_timer_r != 16'h0000) begin
            baud_rate_timer_nxt = baud_rate_timer_r - 16'h0001;
        end else begin
            baud_rate_timer_nxt = divisor;
            presc_nxt = (presc_r >= presc_top) ? 4'h0 : presc_r + 4'h1;
        end
        // Narrow mode drops a count left over from wide mode
        if (!ctrl.wide_baud_timer_select)
            baud_rate_timer_nxt[15:8] = 8'h00;
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            baud_rate_timer_r <= 16'h0000;
            presc_r           <= 4'h0;
        end else begin
            baud_rate_timer_r <= baud_rate_timer_nxt;
            presc_r           <= presc_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive state machine, sampling mid-bit
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_START = 4'h2,
        ST_DATA  = 4'h4,
        ST_STOP  = 4'h8
    } rx_state_t;

    rx_state_t        state_r, state_nxt;
    logic [1:0]       phase_r, phase_nxt;
    logic [3:0]       bit_cnt_r, bit_cnt_nxt;
    logic [8:0]       receive_shift_register_r, receive_shift_register_nxt;
    logic             char_done;
    logic             rx_en;
    // Start hunt only after the line was seen high; a low stop bit is no start
    logic             armed_r, armed_nxt;
    logic [3:0]       last_bit;
    uart_rx_pkg::rx_char_t done_char;

    assign rx_en    = ctrl.serial_port_enable && ctrl.continuous_receive_enable;
    assign last_bit = ctrl.nine_bit_receive_select ? 4'h8 : 4'h7;

    always_comb begin
        state_nxt = state_r;
        phase_nxt = phase_r;
        bit_cnt_nxt = bit_cnt_r;
        receive_shift_register_nxt = receive_shift_register_r;
        armed_nxt = armed_r;
        char_done = 1'b0;
        done_char = '0;
        if (!rx_en) begin
            state_nxt = ST_IDLE;
        end else if (sample_tick) begin
            phase_nxt = phase_r + 2'h1;
            case (state_r)
                ST_IDLE: begin
                    if (rx_line)
                        armed_nxt = 1'b1;
                    else if (armed_r) begin
                        state_nxt = ST_START;
                        phase_nxt = 2'h1;
                    end
                end
                ST_START: begin
                    if (phase_r == 2'h1 && rx_line)
                        state_nxt = ST_IDLE;               // Glitch, not a start bit
                    else if (phase_r == 2'h3) begin
                        state_nxt = ST_DATA;
                        bit_cnt_nxt = 4'h0;
                    end
                end
                ST_DATA: begin
                    if (phase_r == 2'h1)
                        receive_shift_register_nxt[bit_cnt_r] = rx_line;
                    if (phase_r == 2'h3) begin
                        if (bit_cnt_r == last_bit)
                            state_nxt = ST_STOP;
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end
                end
                ST_STOP: begin
                    if (phase_r == 2'h1) begin
                        char_done = 1'b1;
                        done_char.data = receive_shift_register_r[7:0];
                        done_char.ninth = ctrl.nine_bit_receive_select
                                          && receive_shift_register_r[8];
                        done_char.framing_err = !rx_line;
                        state_nxt = ST_IDLE;
                        // A low stop bit must go high before a new start counts
                        armed_nxt = rx_line;
                    end
                end
                default: state_nxt = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            phase_r <= 2'h0;
            bit_cnt_r <= 4'h0;
            receive_shift_register_r <= 9'h000;
            // Idle line level, so the first start edge is not missed
            armed_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            receive_shift_register_r <= receive_shift_register_nxt;
            armed_r <= armed_nxt;
        end
    end

    assign receive_idle_status = (state_r == ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Address filter, buffer and overrun
    logic keep_char, push_valid, push_ready;
    logic ovr_r, ovr_nxt;
    logic buf_valid;
    uart_rx_pkg::rx_char_t head;

    always_comb begin
        keep_char = char_done;
        if (ctrl.address_detect_enable && ctrl.nine_bit_receive_select)
            keep_char = char_done && done_char.ninth;
        push_valid = keep_char && !ovr_r;
        ovr_nxt = ovr_r;
        if (!ctrl.continuous_receive_enable)
            ovr_nxt = 1'b0;
        else if (keep_char && !push_ready)
            ovr_nxt = 1'b1;
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst)
            ovr_r <= 1'b0;
        else
            ovr_r <= ovr_nxt;
    end

    rx_char_buffer #(
        .DEPTH(uart_rx_pkg::BUF_DEPTH)
    ) u_buf (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .in_valid (push_valid),
        .in_ready (push_ready),
        .in_data  (done_char),
        .out_valid(buf_valid),
        .out_ready(receive_data_read),
        .out_data (head)
    );

    assign receive_data_reg       = head.data;
    assign rx_ninth_bit           = head.ninth;
    assign framing_error_flag     = head.framing_err;
    assign overrun_error_flag     = ovr_r;
    assign receive_interrupt_flag = buf_valid;
    assign irq = buf_valid && irq_en.receive_interrupt_enable
                 && irq_en.peripheral_interrupt_enable
                 && irq_en.global_interrupt_enable;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    irq_gate_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        irq |-> (receive_interrupt_flag && irq_en.receive_interrupt_enable
                 && irq_en.peripheral_interrupt_enable && irq_en.global_interrupt_enable))
        else $error("irq without flag or enables");
    irq_all_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (receive_interrupt_flag && irq_en.receive_interrupt_enable
         && irq_en.peripheral_interrupt_enable && irq_en.global_interrupt_enable) |-> irq)
        else $error("irq missing with flag and enables");
    narrow_ninth_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (char_done && !ctrl.nine_bit_receive_select) |-> !done_char.ninth)
        else $error("ninth bit set in eight-bit mode");
    rx_gate_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        !rx_en |=> state_r == ST_IDLE)
        else $error("receiver active while disabled");
    rx_off_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        !rx_en |-> !char_done)
        else $error("character completed while disabled");
    flag_set_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (push_valid && push_ready) |=> receive_interrupt_flag)
        else $error("flag not set after buffer load");
    head_stable_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (receive_interrupt_flag && !receive_data_read) |=> $stable(receive_data_reg))
        else $error("oldest character changed without a read");

    // Overrun and address filter
    ovr_clear_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        !ctrl.continuous_receive_enable |=> !overrun_error_flag)
        else $error("overrun not cleared");
    ovr_set_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (keep_char && !push_ready && ctrl.continuous_receive_enable) |=> overrun_error_flag)
        else $error("overrun not raised on full buffer");
    ovr_hold_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (overrun_error_flag && ctrl.continuous_receive_enable) |=> overrun_error_flag)
        else $error("overrun cleared while receive enabled");
    addr_drop_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (char_done && ctrl.address_detect_enable && ctrl.nine_bit_receive_select
         && !done_char.ninth) |-> !push_valid)
        else $error("non-address char buffered");
    addr_ninth_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (push_valid && ctrl.address_detect_enable && ctrl.nine_bit_receive_select)
        |-> done_char.ninth)
        else $error("address char buffered without ninth bit");
    all_keep_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (char_done && !ctrl.address_detect_enable && !ovr_r) |-> push_valid)
        else $error("char dropped with detect off");

    // Baud timer and idle status
    wide_timer_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        !ctrl.wide_baud_timer_select && !divisor_write
        |=> baud_rate_timer_r[15:8] == 8'h00)
        else $error("narrow timer exceeded 8 bits");
    timer_wrap_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (baud_rate_timer_r == 16'h0000 && !divisor_write)
        |=> baud_rate_timer_r == $past(divisor))
        else $error("timer did not reload the divisor");
    timer_reload_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        divisor_write |=> (baud_rate_timer_r == $past(divisor) && presc_r == 4'h0))
        else $error("divisor write did not reset timer");
    idle_status_a: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (receive_idle_status && rx_en && sample_tick && !rx_line && armed_r)
        |=> !receive_idle_status)
        else $error("idle shown during reception");
endmodule : uart_receiver

/* File: tb/serial_sender.sv */
// Remote asynchronous transmitter model that drives the receive line
`timescale 1ns/1ps
module serial_sender (
    input  wire logic clk_sys,
    output logic      rx_line
);
    initial rx_line = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // One frame, changed just after each falling edge; line idles high afterwards
    task automatic send_char(input logic [7:0] data, input logic ninth, input logic nine,
                             input logic stop_bit, input int unsigned bit_clks);
        logic [10:0] frame;
        int unsigned n;
        frame = nine ? {stop_bit, ninth, data, 1'b0} : {1'b1, stop_bit, data, 1'b0};
        n = nine ? 11 : 10;
        for (int i = 0; i < n; i++) begin
            @(negedge clk_sys);
            rx_line = frame[i];
            repeat (bit_clks - 1) @(negedge clk_sys);
        end
        @(negedge clk_sys);
        rx_line = 1'b1;
    endtask : send_char
endmodule : serial_sender

/* File: tb/testbench.sv */
// Self-checking bench for the asynchronous serial receiver
`timescale 1ns/1ps
module testbench;
    logic                  clk_sys;
    logic                  nrst;
    logic                  rx_line;
    uart_rx_pkg::rx_ctrl_t ctrl;
    uart_rx_pkg::irq_en_t  irq_en;
    logic [7:0]            div_hi;
    logic [7:0]            div_lo;
    logic                  divisor_write;
    logic                  rd;
    logic [7:0]            data;
    logic                  ninth;
    logic                  ferr;
    logic                  ovr;
    logic                  flag;
    logic                  idle;
    logic                  irq;
    int unsigned           n_mismatch;
    int unsigned           checked;
    int unsigned           bit_clks;
    logic [7:0]            d;

    uart_receiver u_dut (.clk_sys(clk_sys), .nrst(nrst), .rx_line(rx_line), .ctrl(ctrl),
        .irq_en(irq_en), .baud_divisor_high(div_hi), .baud_divisor_low(div_lo),
        .divisor_write(divisor_write), .receive_data_read(rd), .receive_data_reg(data),
        .rx_ninth_bit(ninth), .framing_error_flag(ferr), .overrun_error_flag(ovr),
        .receive_interrupt_flag(flag), .receive_idle_status(idle), .irq(irq));
    serial_sender u_tx (.clk_sys(clk_sys), .rx_line(rx_line));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_byte

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : cmp_bit

    function automatic int unsigned bit_period(logic hs, logic wide, logic [7:0] hi,
                                               logic [7:0] lo);
        int unsigned mult;
        int unsigned div;
        mult = (hs && wide) ? 4 : ((hs || wide) ? 16 : 64);
        div = wide ? {hi, lo} : lo;
        return (div + 1) * mult;
    endfunction : bit_period

    task automatic set_baud(input logic hs, input logic wide, input logic [7:0] hi,
                            input logic [7:0] lo);
        @(negedge clk_sys);
        ctrl.high_speed_baud_select = hs;
        ctrl.wide_baud_timer_select = wide;
        div_hi = hi;
        div_lo = lo;
        divisor_write = 1'b1;
        @(negedge clk_sys);
        divisor_write = 1'b0;
        bit_clks = bit_period(hs, wide, hi, lo);
    endtask : set_baud

    task automatic send(input logic [7:0] v, input logic nb, input logic stop_bit);
        u_tx.send_char(v, nb, ctrl.nine_bit_receive_select, stop_bit, bit_clks);
        repeat (4) @(negedge clk_sys);
    endtask : send

    // Status is read before the data, then the oldest character is popped
    task automatic expect_char(input logic [7:0] v, input logic nb, input logic fe);
        for (int i = 0; i < 20 && flag !== 1'b1; i++) @(negedge clk_sys);
        cmp_bit("flag", 1'b1, flag);
        cmp_bit("ninth", nb, ninth);
        cmp_bit("framing", fe, ferr);
        cmp_byte("data", v, data);
        rd = 1'b1;
        @(negedge clk_sys);
        rd = 1'b0;
        @(negedge clk_sys);
    endtask : expect_char

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_mismatch++;
        $display("watchdog expired");
        finish_test();
    end

    initial begin
        logic [7:0] keep [2];
        nrst = 1'b0;
        ctrl = '0;
        irq_en = '0;
        div_hi = 8'h00;
        div_lo = 8'h00;
        divisor_write = 1'b0;
        rd = 1'b0;
        n_mismatch = 0;
        checked = 0;
        bit_clks = 4;
        void'($urandom(32'h09615ECE));
        repeat (5) @(negedge clk_sys);
        nrst = 1'b1;
        @(negedge clk_sys);
        cmp_bit("idle after reset", 1'b1, idle);
        ctrl.serial_port_enable = 1'b1;
        ctrl.continuous_receive_enable = 1'b1;
        // Every multiplier pairing; last one needs the high divisor byte
        for (int m = 0; m < 4; m++) begin
            set_baud(m[0], m[1], (m == 3) ? 8'h01 : 8'h00, 8'($urandom_range(0, 2)));
            d = 8'($urandom);
            send(d, 1'b0, 1'b1);
            expect_char(d, 1'b0, 1'b0);
        end
        $display("test baud_modes done");
        set_baud(1'b1, 1'b1, 8'h00, 8'h00);
        d = 8'($urandom);
        fork
            send(d, 1'b0, 1'b1);
            begin
                repeat (bit_clks * 3) @(negedge clk_sys);
                cmp_bit("idle busy", 1'b0, idle);
            end
        join
        cmp_bit("idle done", 1'b1, idle);
        for (int e = 0; e < 8; e++) begin
            irq_en = 3'(e);
            @(negedge clk_sys);
            cmp_bit("irq", &3'(e), irq);
        end
        expect_char(d, 1'b0, 1'b0);
        cmp_bit("irq empty", 1'b0, irq);
        $display("test irq_idle done");
        ctrl.nine_bit_receive_select = 1'b1;
        for (int b = 0; b < 2; b++) begin
            d = 8'($urandom);
            send(d, b[0], 1'b1);
            expect_char(d, b[0], 1'b0);
        end
        ctrl.address_detect_enable = 1'b1;
        send(8'($urandom), 1'b0, 1'b1);
        cmp_bit("addr drop", 1'b0, flag);
        d = 8'($urandom);
        send(d, 1'b1, 1'b1);
        expect_char(d, 1'b1, 1'b0);
        ctrl.address_detect_enable = 1'b0;
        d = 8'($urandom);
        send(d, 1'b0, 1'b1);
        expect_char(d, 1'b0, 1'b0);
        ctrl.nine_bit_receive_select = 1'b0;
        $display("test address done");
        d = 8'($urandom);
        send(d, 1'b0, 1'b0);
        expect_char(d, 1'b0, 1'b1);
        $display("test framing done");
        // Third character finds the buffer full
        keep[0] = 8'h00;
        keep[1] = 8'hFF;
        send(keep[0], 1'b0, 1'b1);
        send(keep[1], 1'b0, 1'b1);
        send(8'h5A, 1'b0, 1'b1);
        cmp_bit("overrun set", 1'b1, ovr);
        expect_char(keep[0], 1'b0, 1'b0);
        expect_char(keep[1], 1'b0, 1'b0);
        send(8'hA5, 1'b0, 1'b1);
        cmp_bit("overrun drop", 1'b0, flag);
        cmp_bit("overrun held", 1'b1, ovr);
        ctrl.continuous_receive_enable = 1'b0;
        repeat (2) @(negedge clk_sys);
        cmp_bit("overrun clear", 1'b0, ovr);
        send(8'h3C, 1'b0, 1'b1);
        cmp_bit("disabled drop", 1'b0, flag);
        ctrl.continuous_receive_enable = 1'b1;
        d = 8'($urandom);
        send(d, 1'b0, 1'b1);
        expect_char(d, 1'b0, 1'b0);
        $display("test overrun done");
        finish_test();
    end
endmodule : testbench
